// File: verilog/dbtf_pkg.sv
// constants and types shared by the burst transmit framer
package dbtf_pkg;
    // register port
    localparam int          REG_AW           = 4;
    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_CODE_A       = 4'h1;
    localparam logic [3:0]  REG_CODE_C       = 4'h2;
    localparam logic [3:0]  REG_CHIP_DIV     = 4'h3;
    localparam logic [3:0]  REG_SYM_LEN      = 4'h4;
    localparam logic [3:0]  REG_STATUS       = 4'h5;
    localparam logic [3:0]  REG_COUNTS       = 4'h6;
    // control field positions
    localparam int          CTRL_TEST_BIT    = 0;
    localparam int          CTRL_REF_RX_BIT  = 1;
    localparam int          CTRL_REF_TX_BIT  = 2;
    localparam int          CTRL_REF_PNL_BIT = 3;
    // values after reset
    localparam logic [3:0]  CTRL_RST         = 4'h0;
    localparam logic [10:0] CODE_A_RST       = 11'h001;
    localparam logic [10:0] CODE_C_RST       = 11'h001;
    localparam logic [15:0] CHIP_DIV_RST     = 16'h0003;
    localparam logic [15:0] SYM_LEN_RST      = 16'h0040;
    localparam logic [10:0] PRBS_SEED        = 11'h7ff;
    // frame and burst layout
    localparam int          IN_W             = 32;
    localparam int          FRAME_BITS       = 512;
    localparam logic [9:0]  WORDS_PER_FRAME  = 10'h010;
    localparam logic [9:0]  FRAME_BITS_CNT   = 10'h200;
    localparam int          FIFO_DEPTH       = 16;
    localparam logic [10:0] CODED_BITS       = 11'h410;
    localparam int          TAIL_BITS        = 16;
    localparam logic [10:0] PRE0_SYMS        = 11'h320;
    localparam logic [10:0] PRE1_SYMS        = 11'h320;
    localparam logic [10:0] SYNC_BITS        = 11'h020;
    localparam logic [31:0] SYNC_WORD        = 32'h1acffc1d;
    // convolutional code, constraint length 9
    localparam logic [8:0]  CONV_G1          = 9'o753;
    localparam logic [8:0]  CONV_G2          = 9'o561;
    // gold code
    localparam logic [10:0] CODE_LAST        = 11'h7fe;
    // test frame period
    localparam int          CLK_HZ           = 125_000_000;
    localparam int          TEST_PERIOD_MS   = 100;
    localparam int          TEST_PERIOD_CYC  = CLK_HZ / 1000 * TEST_PERIOD_MS;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PRE0 = 5'b00010,
        ST_PRE1 = 5'b00100,
        ST_SYNC = 5'b01000,
        ST_DATA = 5'b10000
    } dbtf_tx_e;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dbtf_req_s;

    typedef struct packed {
        logic [3:0]             ctrl;
        logic [10:0]            code_a_init;
        logic [10:0]            code_c_init;
        logic [15:0]            chip_div;
        logic [15:0]            sym_len;
        logic [31:0]            rdata;
        logic [FRAME_BITS-1:0]  asm_frame;
        logic [9:0]             asm_cnt;
        logic                   asm_full;
        logic [23:0]            test_cnt;
        logic                   test_fill;
        logic [10:0]            prbs;
        dbtf_tx_e               tx_st;
        logic [FRAME_BITS-1:0]  frame;
        logic [7:0]             enc_sr;
        logic [10:0]            sym_cnt;
        logic [15:0]            div_cnt;
        logic [15:0]            chip_cnt;
        logic [10:0]            lfsr_a;
        logic [10:0]            lfsr_c;
        logic [10:0]            code_cnt;
        logic                   chip;
        logic                   chip_vld;
        logic [15:0]            frames_sent;
        logic [15:0]            dropped;
    } dbtf_state_s;
endpackage : dbtf_pkg

// File: verilog/dbtf_fifo.sv
// elastic buffer: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module dbtf_fifo #(
    parameter int WIDTH = 512,
    parameter int DEPTH = 16
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_in_valid,
    input  wire logic [WIDTH-1:0]         i_in_data,
    output      logic                     o_in_ready,
    output      logic                     o_out_valid,
    output      logic [WIDTH-1:0]         o_out_data,
    input  wire logic                     i_out_ready,
    output      logic [$clog2(DEPTH):0]   o_count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } dbtf_fifo_s;

    dbtf_fifo_s st_ff;
    dbtf_fifo_s nxt_st;
    logic       push;
    logic       pop;

    // full and empty come straight from the occupancy count
    assign o_in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_ff.cnt != '0);
    assign o_out_data  = st_ff.mem[st_ff.rp];
    assign o_count     = st_ff.cnt;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // pointer and count update; simultaneous push and pop keep the count
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = i_in_data;
            nxt_st.wp            = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : dbtf_fifo

// File: verilog/dbtf_top.sv
// burst transmit framer: frame intake, elastic buffer, encoder, spreader
`timescale 1ns/1ps
module dbtf_top #(
    parameter int TEST_PERIOD_CYC = dbtf_pkg::TEST_PERIOD_CYC
) (
    input  wire logic                      I_CLK_SYS,
    input  wire logic                      I_ARST_N,
    input  wire logic [3:0]                I_REG_ADDR,
    input  wire logic [31:0]               I_REG_WDATA,
    input  wire logic                      I_REG_WR,
    input  wire logic                      I_REG_RD,
    output      logic [31:0]               O_REG_RDATA,
    input  wire logic                      I_IN_VALID,
    input  wire logic [31:0]               I_IN_DATA,
    output      logic                      O_IN_READY,
    output      logic                      O_CHIP,
    output      logic                      O_CHIP_VALID,
    output      logic                      O_BURST_ACTIVE,
    output      logic                      O_REF_EN_RX,
    output      logic                      O_REF_EN_TX,
    output      logic                      O_REF_EN_PANEL
);
    dbtf_pkg::dbtf_state_s  st_ff;
    dbtf_pkg::dbtf_state_s  nxt_st;
    dbtf_pkg::dbtf_req_s    req;
    logic                   fifo_push;
    logic                   fifo_in_ready;
    logic                   fifo_valid;
    logic [511:0]           fifo_data;
    logic                   fifo_pop;
    logic [4:0]             fifo_cnt;
    logic                   test_mode;
    logic                   chip_en;
    logic                   sym_end;
    logic                   sym_bit;
    logic                   code_bit;
    logic                   in_bit;
    logic [8:0]             enc_win;
    logic [10:0]            sym_last;
    logic                   take_word;

    assign req       = '{addr: I_REG_ADDR, wdata: I_REG_WDATA, wr: I_REG_WR, rd: I_REG_RD};
    assign test_mode = st_ff.ctrl[dbtf_pkg::CTRL_TEST_BIT];

    // intake: a full frame waits here until the buffer has room, which stalls the source outside test mode
    assign O_IN_READY = test_mode || !st_ff.asm_full;
    assign take_word  = I_IN_VALID && !test_mode && !st_ff.asm_full;
    assign fifo_push  = st_ff.asm_full;

    // sixteen frames of 512 bits make the 8 kbit elastic buffer
    dbtf_fifo #(
        .WIDTH (dbtf_pkg::FRAME_BITS),
        .DEPTH (dbtf_pkg::FIFO_DEPTH)
    ) u_buf (
        .i_clk       (I_CLK_SYS),
        .i_arst_n    (I_ARST_N),
        .i_in_valid  (fifo_push),
        .i_in_data   (st_ff.asm_frame),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop),
        .o_count     (fifo_cnt)
    );

    // chip and symbol timing run only inside a burst
    assign chip_en  = (st_ff.tx_st != dbtf_pkg::ST_IDLE) && (st_ff.div_cnt == 16'h0000);
    assign sym_end  = chip_en && (st_ff.chip_cnt == st_ff.sym_len - 16'h0001);
    assign code_bit = st_ff.lfsr_a[0] ^ st_ff.lfsr_c[0];

    // encoder window: newest bit on top, older bits below
    assign in_bit  = st_ff.frame[0];
    assign enc_win = {in_bit, st_ff.enc_sr};

    // last symbol index of the current field
    always_comb begin
        unique case (st_ff.tx_st)
            dbtf_pkg::ST_PRE0: sym_last = dbtf_pkg::PRE0_SYMS - 11'h001;
            dbtf_pkg::ST_PRE1: sym_last = dbtf_pkg::PRE1_SYMS - 11'h001;
            dbtf_pkg::ST_SYNC: sym_last = dbtf_pkg::SYNC_BITS - 11'h001;
            dbtf_pkg::ST_DATA: sym_last = dbtf_pkg::CODED_BITS - 11'h001;
            default:           sym_last = 11'h000;
        endcase
    end

    // symbol value of each field before spreading
    always_comb begin
        unique case (st_ff.tx_st)
            dbtf_pkg::ST_PRE0: sym_bit = 1'b0;
            dbtf_pkg::ST_PRE1: sym_bit = st_ff.sym_cnt[0];
            dbtf_pkg::ST_SYNC: sym_bit = dbtf_pkg::SYNC_WORD[5'(11'h01f - st_ff.sym_cnt)];
            dbtf_pkg::ST_DATA: begin
                // even symbols carry the first generator, odd the second
                sym_bit = st_ff.sym_cnt[0] ? ^(enc_win & dbtf_pkg::CONV_G2)
                                           : ^(enc_win & dbtf_pkg::CONV_G1);
            end
            default:           sym_bit = 1'b0;
        endcase
    end

    // a frame is taken from the buffer when idle or at the end of a payload
    assign fifo_pop = fifo_valid &&
                      ((st_ff.tx_st == dbtf_pkg::ST_IDLE) ||
                       ((st_ff.tx_st == dbtf_pkg::ST_DATA) && sym_end &&
                        (st_ff.sym_cnt == sym_last)));

    // next state of everything
    always_comb begin
        nxt_st = st_ff;

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                dbtf_pkg::REG_CTRL: begin
                    nxt_st.ctrl = req.wdata[3:0];
                    // a mode change throws away a half-built frame unless a word or fill bit is taken in the same cycle
                    if (req.wdata[dbtf_pkg::CTRL_TEST_BIT] != test_mode) begin
                        nxt_st.asm_cnt   = 10'h000;
                        nxt_st.test_fill = 1'b0;
                        nxt_st.test_cnt  = 24'(TEST_PERIOD_CYC - 1);
                    end
                end
                dbtf_pkg::REG_CODE_A:   nxt_st.code_a_init = req.wdata[10:0];
                dbtf_pkg::REG_CODE_C:   nxt_st.code_c_init = req.wdata[10:0];
                dbtf_pkg::REG_CHIP_DIV: nxt_st.chip_div    = req.wdata[15:0];
                dbtf_pkg::REG_SYM_LEN:  nxt_st.sym_len     = req.wdata[15:0];
                default: ;
            endcase
        end

        // register reads answer in the next cycle; unmapped reads give zero
        nxt_st.rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                dbtf_pkg::REG_CTRL:     nxt_st.rdata = {28'h0000000, st_ff.ctrl};
                dbtf_pkg::REG_CODE_A:   nxt_st.rdata = {21'h000000, st_ff.code_a_init};
                dbtf_pkg::REG_CODE_C:   nxt_st.rdata = {21'h000000, st_ff.code_c_init};
                dbtf_pkg::REG_CHIP_DIV: nxt_st.rdata = {16'h0000, st_ff.chip_div};
                dbtf_pkg::REG_SYM_LEN:  nxt_st.rdata = {16'h0000, st_ff.sym_len};
                dbtf_pkg::REG_STATUS: begin
                    nxt_st.rdata = {11'h000, fifo_cnt, 10'h000, st_ff.asm_full, st_ff.tx_st};
                end
                dbtf_pkg::REG_COUNTS:   nxt_st.rdata = {st_ff.dropped, st_ff.frames_sent};
                default:                nxt_st.rdata = 32'h0000_0000;
            endcase
        end

        // buffer accepted the assembled frame
        if (st_ff.asm_full && fifo_in_ready) begin
            nxt_st.asm_full = 1'b0;
        end

        // packet intake: sixteen words make one frame, first word in the low bits
        if (take_word) begin
            nxt_st.asm_frame = {I_IN_DATA, st_ff.asm_frame[511:32]};
            nxt_st.asm_cnt   = st_ff.asm_cnt + 10'h001;
            if (st_ff.asm_cnt == dbtf_pkg::WORDS_PER_FRAME - 10'h001) begin
                nxt_st.asm_cnt  = 10'h000;
                nxt_st.asm_full = 1'b1;
            end
        end

        // words offered in test mode are dropped and counted
        if (test_mode && I_IN_VALID) begin
            nxt_st.dropped = st_ff.dropped + 16'h0001;
        end

        // test mode: period timer starts a frame fill
        if (test_mode) begin
            if (st_ff.test_cnt == 24'h000000) begin
                nxt_st.test_cnt = 24'(TEST_PERIOD_CYC - 1);
                // a fill already under way is not restarted
                if (!st_ff.test_fill && !st_ff.asm_full) begin
                    nxt_st.test_fill = 1'b1;
                    nxt_st.asm_cnt   = 10'h000;
                end
            end else begin
                nxt_st.test_cnt = st_ff.test_cnt - 24'h000001;
            end
        end

        // test fill: one PRBS11 bit per clock, x^11 + x^9 + 1
        if (st_ff.test_fill && !st_ff.asm_full) begin
            nxt_st.prbs      = {st_ff.prbs[9:0], st_ff.prbs[10] ^ st_ff.prbs[8]};
            nxt_st.asm_frame = {st_ff.prbs[10], st_ff.asm_frame[511:1]};
            nxt_st.asm_cnt   = st_ff.asm_cnt + 10'h001;
            if (st_ff.asm_cnt == dbtf_pkg::FRAME_BITS_CNT - 10'h001) begin
                nxt_st.asm_cnt   = 10'h000;
                nxt_st.test_fill = 1'b0;
                nxt_st.asm_full  = 1'b1;
            end
        end

        // chip divider and chip-within-symbol counter
        nxt_st.chip_vld = chip_en;
        if (st_ff.tx_st != dbtf_pkg::ST_IDLE) begin
            nxt_st.div_cnt = chip_en ? st_ff.chip_div : st_ff.div_cnt - 16'h0001;
        end
        if (chip_en) begin
            // bpsk: one spread chip, in-phase code only
            nxt_st.chip     = sym_bit ^ code_bit;
            nxt_st.chip_cnt = sym_end ? 16'h0000 : st_ff.chip_cnt + 16'h0001;
            // code runs free across symbols; 2047 chips then reload the seeds
            if (st_ff.code_cnt == dbtf_pkg::CODE_LAST) begin
                nxt_st.code_cnt = 11'h000;
                nxt_st.lfsr_a   = st_ff.code_a_init;
                nxt_st.lfsr_c   = st_ff.code_c_init;
            end else begin
                nxt_st.code_cnt = st_ff.code_cnt + 11'h001;
                nxt_st.lfsr_a   = {st_ff.lfsr_a[0] ^ st_ff.lfsr_a[2], st_ff.lfsr_a[10:1]};
                nxt_st.lfsr_c   = {st_ff.lfsr_c[0] ^ st_ff.lfsr_c[2] ^ st_ff.lfsr_c[5]
                                   ^ st_ff.lfsr_c[8], st_ff.lfsr_c[10:1]};
            end
        end

        // encoder advances after the second coded symbol of each input bit
        if (sym_end && (st_ff.tx_st == dbtf_pkg::ST_DATA) && st_ff.sym_cnt[0]) begin
            // zeros shifted in behind the payload flush the tail
            nxt_st.frame  = {1'b0, st_ff.frame[511:1]};
            nxt_st.enc_sr = enc_win[8:1];
        end

        // burst sequencer
        if (sym_end) begin
            nxt_st.sym_cnt = st_ff.sym_cnt + 11'h001;
        end
        unique case (st_ff.tx_st)
            dbtf_pkg::ST_IDLE: begin
                if (fifo_valid) begin
                    // start at once, code and timing from their seeds
                    nxt_st.tx_st    = dbtf_pkg::ST_PRE0;
                    nxt_st.frame    = fifo_data;
                    nxt_st.sym_cnt  = 11'h000;
                    nxt_st.div_cnt  = st_ff.chip_div;
                    nxt_st.chip_cnt = 16'h0000;
                    nxt_st.code_cnt = 11'h000;
                    nxt_st.lfsr_a   = st_ff.code_a_init;
                    nxt_st.lfsr_c   = st_ff.code_c_init;
                end
            end
            dbtf_pkg::ST_PRE0: begin
                if (sym_end && (st_ff.sym_cnt == sym_last)) begin
                    nxt_st.tx_st   = dbtf_pkg::ST_PRE1;
                    nxt_st.sym_cnt = 11'h000;
                end
            end
            dbtf_pkg::ST_PRE1: begin
                if (sym_end && (st_ff.sym_cnt == sym_last)) begin
                    nxt_st.tx_st   = dbtf_pkg::ST_SYNC;
                    nxt_st.sym_cnt = 11'h000;
                end
            end
            dbtf_pkg::ST_SYNC: begin
                if (sym_end && (st_ff.sym_cnt == sym_last)) begin
                    nxt_st.tx_st   = dbtf_pkg::ST_DATA;
                    nxt_st.sym_cnt = 11'h000;
                    nxt_st.enc_sr  = 8'h00;
                end
            end
            dbtf_pkg::ST_DATA: begin
                if (sym_end && (st_ff.sym_cnt == sym_last)) begin
                    nxt_st.sym_cnt     = 11'h000;
                    nxt_st.frames_sent = st_ff.frames_sent + 16'h0001;
                    if (fifo_valid) begin
                        // next frame already whole in the buffer: sync word only
                        nxt_st.tx_st = dbtf_pkg::ST_SYNC;
                        nxt_st.frame = fifo_data;
                    end else begin
                        // nothing queued: close the burst, next one gets preambles
                        nxt_st.tx_st = dbtf_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    // single state register
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_ff             <= '0;
            st_ff.ctrl        <= dbtf_pkg::CTRL_RST;
            st_ff.code_a_init <= dbtf_pkg::CODE_A_RST;
            st_ff.code_c_init <= dbtf_pkg::CODE_C_RST;
            st_ff.chip_div    <= dbtf_pkg::CHIP_DIV_RST;
            st_ff.sym_len     <= dbtf_pkg::SYM_LEN_RST;
            st_ff.prbs        <= dbtf_pkg::PRBS_SEED;
            st_ff.tx_st       <= dbtf_pkg::ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign O_REG_RDATA    = st_ff.rdata;
    assign O_CHIP         = st_ff.chip;
    assign O_CHIP_VALID   = st_ff.chip_vld;
    assign O_BURST_ACTIVE = (st_ff.tx_st != dbtf_pkg::ST_IDLE);
    assign O_REF_EN_RX    = st_ff.ctrl[dbtf_pkg::CTRL_REF_RX_BIT];
    assign O_REF_EN_TX    = st_ff.ctrl[dbtf_pkg::CTRL_REF_TX_BIT];
    assign O_REF_EN_PANEL = st_ff.ctrl[dbtf_pkg::CTRL_REF_PNL_BIT];
endmodule : dbtf_top

// File: tb/dbtf_chk.sv
// checker: port-level assertions for the burst framer
`timescale 1ns/1ps
module dbtf_chk (
    input wire logic        I_CLK_SYS, I_ARST_N, I_REG_WR, I_REG_RD, I_IN_VALID,
    input wire logic        O_IN_READY, O_CHIP, O_CHIP_VALID, O_BURST_ACTIVE,
    input wire logic        O_REF_EN_RX, O_REF_EN_TX, O_REF_EN_PANEL,
    input wire logic [3:0]  I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA, I_IN_DATA, O_REG_RDATA
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_ARST_N);
    logic       test_ff, ctrl_wr, take;
    logic [3:0] wcnt_ff;
    assign ctrl_wr = I_REG_WR && I_REG_ADDR == dbtf_pkg::REG_CTRL;
    assign take    = I_IN_VALID && O_IN_READY && !test_ff;
    // mirror of test mode and word slot; a test toggle drops the partial frame
    always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            test_ff <= 1'b0;
            wcnt_ff <= 4'h0;
        end else begin
            if (ctrl_wr) test_ff <= I_REG_WDATA[0];
            if (ctrl_wr && I_REG_WDATA[0] != test_ff) wcnt_ff <= 4'h0;
            else if (take) wcnt_ff <= wcnt_ff + 4'h1;
        end
    end
    property p_ref_rx; ctrl_wr |=> O_REF_EN_RX == $past(I_REG_WDATA[1]); endproperty
    property p_ref_tx; ctrl_wr |=> O_REF_EN_TX == $past(I_REG_WDATA[2]); endproperty
    property p_ref_pnl; ctrl_wr |=> O_REF_EN_PANEL == $past(I_REG_WDATA[3]); endproperty
    property p_ref_hold;
        !ctrl_wr |=> $stable({O_REF_EN_RX, O_REF_EN_TX, O_REF_EN_PANEL});
    endproperty
    property p_frame_full; take && wcnt_ff == 4'hf |=> !O_IN_READY; endproperty
    property p_test_drop; test_ff |-> O_IN_READY; endproperty
    property p_start; take && wcnt_ff == 4'hf && !O_BURST_ACTIVE |-> ##[1:4] O_BURST_ACTIVE;
    endproperty
    property p_spread; O_CHIP_VALID |-> O_BURST_ACTIVE || $past(O_BURST_ACTIVE); endproperty
    property p_first_chip; $rose(O_BURST_ACTIVE) |-> ##[1:20] O_CHIP_VALID; endproperty
    a_ref_rx: assert property (p_ref_rx) else $error("rx enable missed write");
    a_ref_tx: assert property (p_ref_tx) else $error("tx enable missed write");
    a_ref_pnl: assert property (p_ref_pnl) else $error("panel enable missed write");
    a_ref_hold: assert property (p_ref_hold) else $error("enable moved unbidden");
    a_frame_full: assert property (p_frame_full) else $error("ready after word 16");
    a_test_drop: assert property (p_test_drop) else $error("test mode stalls input");
    a_start: assert property (p_start) else $error("burst start late");
    a_spread: assert property (p_spread) else $error("chip outside burst");
    a_first_chip: assert property (p_first_chip) else $error("no early chip");
    c_burst: cover property ($rose(O_BURST_ACTIVE));
    c_chain: cover property (take && wcnt_ff == 4'hf && O_BURST_ACTIVE);
    c_test: cover property (test_ff && I_IN_VALID);
endmodule : dbtf_chk

// File: tb/dbtf_src.sv
// packet source model: hands out 16-word frames on request
`timescale 1ns/1ps
module dbtf_src (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_go,
    input  wire logic        i_ready,
    output      logic        o_valid,
    output      logic [31:0] o_data
);
    logic [5:0]  left_ff;
    logic [31:0] word_ff;
    // word held until taken; idle bus shows inverted data so stale reads show
    assign o_valid = left_ff != 6'h0;
    assign o_data  = o_valid ? word_ff * 32'h9e37 : ~word_ff;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            left_ff <= 6'h0;
            word_ff <= 32'h0;
        end else begin
            left_ff <= left_ff + (i_go ? 6'h10 : 6'h0) - 6'(o_valid && i_ready);
            word_ff <= word_ff + 32'(o_valid && i_ready);
        end
    end
endmodule : dbtf_src

// File: tb/dbtf_top_tb.sv
// testbench: registers, frame traffic, burst lengths and test mode
`timescale 1ns/1ps
module dbtf_top_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, in_data, sh = 32'h0;
    logic        in_valid, in_ready, chip, chip_vld, busy, en_rx, en_tx, en_pnl;
    int          fail_count = 0, samples_checked = 0, cycles = 0, chips = 0;
    localparam logic [31:0] RST_V [5] = '{32'h0, 32'h1, 32'h1, 32'h3, 32'h40};
    always #4 clk = ~clk;
    dbtf_top #(.TEST_PERIOD_CYC(3000)) u_dbtf_top (.I_CLK_SYS(clk), .I_ARST_N(rst_n),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
        .O_REG_RDATA(rdata), .I_IN_VALID(in_valid), .I_IN_DATA(in_data),
        .O_IN_READY(in_ready), .O_CHIP(chip), .O_CHIP_VALID(chip_vld),
        .O_BURST_ACTIVE(busy), .O_REF_EN_RX(en_rx), .O_REF_EN_TX(en_tx),
        .O_REF_EN_PANEL(en_pnl));
    dbtf_src u_dbtf_src (.i_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_ready(in_ready),
        .o_valid(in_valid), .o_data(in_data));
    // chip tally and hang guard; the ceiling counts cycles from time zero and leaves margin over the whole run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        // chip history, newest chip in bit 0
        if (chip_vld === 1'b1) begin
            chips <= chips + 1;
            sh    <= {sh[30:0], chip};
        end
        if (cycles == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] got);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : reg_rd
    // request n frames, wait out the burst, compare its chip count
    task automatic send(input int n, input logic [31:0] exp);
        int c0;
        c0 = chips;
        @(posedge clk);
        go <= 1'b1;
        repeat (n) @(posedge clk);
        go <= 1'b0;
        wait (busy === 1'b1);
        wait (busy === 1'b0);
        repeat (3) @(posedge clk);
        chk(32'(chips - c0), exp);
    endtask : send
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        logic [31:0] v;
        int t0, c0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            reg_rd(4'(i), v);
            chk(v, RST_V[i]);
        end
        reg_rd(4'hf, v);
        chk(v, 32'h0);
        reg_wr(dbtf_pkg::REG_CODE_A, 32'hfffff5a5);
        reg_rd(dbtf_pkg::REG_CODE_A, v);
        chk(v, 32'h5a5);
        reg_wr(dbtf_pkg::REG_CTRL, 32'he);
        chk({29'h0, en_rx, en_tx, en_pnl}, 32'h7);
        reg_wr(dbtf_pkg::REG_CTRL, 32'h4);
        chk({29'h0, en_rx, en_tx, en_pnl}, 32'h2);
        reg_wr(dbtf_pkg::REG_CHIP_DIV, 32'h0);
        reg_wr(dbtf_pkg::REG_SYM_LEN, 32'h1);
        send(1, 32'ha70);
        send(2, 32'hea0);
        reg_wr(dbtf_pkg::REG_CHIP_DIV, 32'h1);
        reg_wr(dbtf_pkg::REG_SYM_LEN, 32'h2);
        send(1, 32'h14e0);
        reg_rd(dbtf_pkg::REG_COUNTS, v);
        chk(v, 32'h4);
        reg_rd(dbtf_pkg::REG_STATUS, v);
        chk(v, 32'h1);
        reg_wr(dbtf_pkg::REG_CHIP_DIV, 32'h0);
        reg_wr(dbtf_pkg::REG_SYM_LEN, 32'h1);
        // zero seeds leave the bare symbols on the chip pin
        reg_wr(dbtf_pkg::REG_CODE_A, 32'h0);
        reg_wr(dbtf_pkg::REG_CODE_C, 32'h0);
        c0 = chips;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait (chips == c0 + 800);
        #1 chk(sh, 32'h0);
        wait (chips == c0 + 1600);
        #1 chk(sh, 32'h55555555);
        wait (chips == c0 + 1632);
        #1 chk(sh, dbtf_pkg::SYNC_WORD);
        wait (chips == c0 + 1648);
        #1 chk(sh, 32'hfc1d000d);
        wait (busy === 1'b0);
        // an all-ones seed shows as eleven ones on the first chips
        reg_wr(dbtf_pkg::REG_CODE_C, 32'h7ff);
        c0 = chips;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait (chips == c0 + 11);
        #1 chk({21'h0, sh[10:0]}, 32'h7ff);
        wait (busy === 1'b0);
        reg_wr(dbtf_pkg::REG_CTRL, 32'h1);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge busy);
        #1 t0 = cycles;
        @(posedge busy);
        #1 chk(32'(cycles - t0), 32'hbb8);
        reg_rd(dbtf_pkg::REG_COUNTS, v);
        chk({16'h0, v[31:16]}, 32'h10);
        print_verdict();
    end
endmodule : dbtf_top_tb
bind dbtf_top dbtf_chk u_dbtf_chk (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_IN_VALID(I_IN_VALID),
    .O_IN_READY(O_IN_READY), .O_CHIP(O_CHIP), .O_CHIP_VALID(O_CHIP_VALID),
    .O_BURST_ACTIVE(O_BURST_ACTIVE), .O_REF_EN_RX(O_REF_EN_RX), .O_REF_EN_TX(O_REF_EN_TX),
    .O_REF_EN_PANEL(O_REF_EN_PANEL), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_IN_DATA(I_IN_DATA), .O_REG_RDATA(O_REG_RDATA));
